// ---- bit_branch_xor_pkg.sv ----

`timescale 1ns/100ps

// ****************************************
// Shared types and constants
// ****************************************
package bit_branch_xor_pkg;
	typedef enum logic [3:0] {
		op_none,
		bit_clear_op,
		bit_set_op,
		skip_if_bit_clear_op,
		skip_if_bit_set_op,
		relative_branch_op,
		branch_by_accumulator_op,
		direction_load_op,
		literal_xor_op,
		register_xor_op
	} exec_op_t;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BIT_W = 3;
	localparam int LIT_W = 9;

	// One decoded instruction from the fetch stage
	typedef struct packed {
		logic valid;
		exec_op_t op;
		logic [ADDR_W-1:0] file_addr;
		logic [BIT_W-1:0] bit_sel;
		logic dest_file;
		logic [LIT_W-1:0] literal;
	} exec_req_t;

	// Write port toward the file registers
	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} file_wr_t;

	localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
	localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
	localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
	localparam logic ZERO_RESET = 1'b0;
	localparam logic [DATA_W-1:0] ALL_ZERO = 8'h00;
endpackage : bit_branch_xor_pkg

// ****************************************
// Result unit: bit masks, bit test and xor
// ****************************************
module bit_xor_unit (
	input wire bit_branch_xor_pkg::exec_op_t op_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] file_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic [7:0] literal_in,
	output logic [7:0] result_out,
	output logic zero_out,
	output logic bit_out
);
	// One-hot mask of the selected bit
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction : bit_mask

	// Result per operation
	always_comb begin
		unique case (op_in)
			bit_branch_xor_pkg::bit_clear_op: result_out = file_in & ~bit_mask(bit_sel_in);
			bit_branch_xor_pkg::bit_set_op: result_out = file_in | bit_mask(bit_sel_in);
			bit_branch_xor_pkg::literal_xor_op: result_out = acc_in ^ literal_in;
			bit_branch_xor_pkg::register_xor_op: result_out = acc_in ^ file_in;
			default: result_out = file_in;
		endcase
	end

	assign zero_out = (result_out == bit_branch_xor_pkg::ALL_ZERO);
	assign bit_out = |(file_in & bit_mask(bit_sel_in));
endmodule : bit_xor_unit

// ---- bit_branch_xor_execute.sv ----
`timescale 1ns/100ps

// ****************************************
// Execute stage for bit, branch, direction and xor ops
// ****************************************
module bit_branch_xor_execute #(
	parameter int PC_W = 15
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire bit_branch_xor_pkg::exec_req_t req_in,
	input wire logic [PC_W-1:0] pc_in,
	input wire logic [7:0] file_rd_data_in,
	output bit_branch_xor_pkg::file_wr_t file_wr_out,
	output logic [7:0] acc_out,
	output logic zero_flag_out,
	output logic zero_update_out,
	output logic pc_load_out,
	output logic [PC_W-1:0] pc_target_out,
	output logic flush_out,
	output logic busy_out,
	output logic [7:0] port_a_direction_out,
	output logic [7:0] port_b_direction_out,
	output logic [7:0] port_c_direction_out
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (PC_W < bit_branch_xor_pkg::LIT_W) begin : g_bad_pc
		$error("PC_W must be at least the branch literal width");
	end

	typedef struct packed {
		bit_branch_xor_pkg::file_wr_t wr;
		logic [7:0] acc;
		logic zero;
		logic zero_upd;
		logic pc_load;
		logic [PC_W-1:0] pc_target;
		logic flush;
		logic busy;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
	} state_t;

	state_t q, d;
	logic [7:0] result;
	logic result_zero;
	logic tested_bit;
	logic take;

	// ****************************************
	// Result unit
	// ****************************************
	bit_xor_unit u_unit (
		.op_in(req_in.op),
		.acc_in(q.acc),
		.file_in(file_rd_data_in),
		.bit_sel_in(req_in.bit_sel),
		.literal_in(req_in.literal[7:0]),
		.result_out(result),
		.zero_out(result_zero),
		.bit_out(tested_bit)
	);

	// Requests are taken only outside the discarded second cycle
	assign take = req_in.valid && !q.busy;

	// Next state
	always_comb begin
		d = q;
		d.wr.we = 1'b0;
		d.zero_upd = 1'b0;
		d.pc_load = 1'b0;
		d.flush = 1'b0;
		d.busy = 1'b0;
		if (take) begin
			unique case (req_in.op)
				bit_branch_xor_pkg::op_none: begin
				end
				bit_branch_xor_pkg::bit_clear_op, bit_branch_xor_pkg::bit_set_op: begin
					d.wr.we = 1'b1;
					d.wr.addr = req_in.file_addr;
					d.wr.data = result;
				end
				bit_branch_xor_pkg::skip_if_bit_clear_op: begin
					d.flush = !tested_bit;
					d.busy = !tested_bit;
				end
				bit_branch_xor_pkg::skip_if_bit_set_op: begin
					d.flush = tested_bit;
					d.busy = tested_bit;
				end
				bit_branch_xor_pkg::relative_branch_op: begin
					d.pc_load = 1'b1;
					d.pc_target = pc_in + PC_W'(1) + {{(PC_W-bit_branch_xor_pkg::LIT_W){req_in.literal[8]}}, req_in.literal};
					d.flush = 1'b1;
					d.busy = 1'b1;
				end
				bit_branch_xor_pkg::branch_by_accumulator_op: begin
					d.pc_load = 1'b1;
					d.pc_target = pc_in + PC_W'(1) + PC_W'(q.acc);
					d.flush = 1'b1;
					d.busy = 1'b1;
				end
				bit_branch_xor_pkg::direction_load_op: begin
					if (req_in.file_addr == bit_branch_xor_pkg::DIR_SEL_A) begin
						d.dir_a = q.acc;
					end
					if (req_in.file_addr == bit_branch_xor_pkg::DIR_SEL_B) begin
						d.dir_b = q.acc;
					end
					if (req_in.file_addr == bit_branch_xor_pkg::DIR_SEL_C) begin
						d.dir_c = q.acc;
					end
				end
				bit_branch_xor_pkg::literal_xor_op: begin
					d.acc = result;
					d.zero = result_zero;
					d.zero_upd = 1'b1;
				end
				bit_branch_xor_pkg::register_xor_op: begin
					if (req_in.dest_file == bit_branch_xor_pkg::DEST_FILE) begin
						d.wr.we = 1'b1;
						d.wr.addr = req_in.file_addr;
						d.wr.data = result;
					end else begin
						d.acc = result;
					end
					d.zero = result_zero;
					d.zero_upd = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.acc <= bit_branch_xor_pkg::ACC_RESET;
			q.zero <= bit_branch_xor_pkg::ZERO_RESET;
			q.dir_a <= bit_branch_xor_pkg::DIR_RESET;
			q.dir_b <= bit_branch_xor_pkg::DIR_RESET;
			q.dir_c <= bit_branch_xor_pkg::DIR_RESET;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign file_wr_out = q.wr;
	assign acc_out = q.acc;
	assign zero_flag_out = q.zero;
	assign zero_update_out = q.zero_upd;
	assign pc_load_out = q.pc_load;
	assign pc_target_out = q.pc_target;
	assign flush_out = q.flush;
	assign busy_out = q.busy;
	assign port_a_direction_out = q.dir_a;
	assign port_b_direction_out = q.dir_b;
	assign port_c_direction_out = q.dir_c;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_bit_clear_write: assert property (
		take && req_in.op == bit_branch_xor_pkg::bit_clear_op |=>
		file_wr_out.we && !file_wr_out.data[$past(req_in.bit_sel)] && !zero_update_out && zero_flag_out == $past(q.zero))
		else $error("bit clear did not clear the bit");
	a_bit_set_write: assert property (
		take && req_in.op == bit_branch_xor_pkg::bit_set_op |=>
		file_wr_out.we && file_wr_out.data[$past(req_in.bit_sel)] && !zero_update_out)
		else $error("bit set did not set the bit");
	a_skip_clear_flush: assert property (
		take && req_in.op == bit_branch_xor_pkg::skip_if_bit_clear_op |=>
		flush_out == !$past(tested_bit) && busy_out == flush_out)
		else $error("skip on clear wrong");
	a_skip_set_flush: assert property (
		take && req_in.op == bit_branch_xor_pkg::skip_if_bit_set_op |=>
		flush_out == $past(tested_bit) && busy_out == flush_out)
		else $error("skip on set wrong");
	// The discarded cycle lasts one cycle and takes no request
	a_busy_one_cycle: assert property (
		busy_out |=> !busy_out && !file_wr_out.we && !pc_load_out && !zero_update_out && $stable(acc_out))
		else $error("discarded cycle was not idle");
	a_branch_target: assert property (
		take && req_in.op == bit_branch_xor_pkg::relative_branch_op |=>
		pc_load_out && busy_out && pc_target_out ==
		$past(pc_in) + PC_W'(1) + {{(PC_W-9){$past(req_in.literal[8])}}, $past(req_in.literal)})
		else $error("relative branch target wrong");
	a_acc_branch_target: assert property (
		take && req_in.op == bit_branch_xor_pkg::branch_by_accumulator_op |=>
		pc_load_out && pc_target_out == $past(pc_in) + PC_W'(1) + PC_W'($past(acc_out)) ##1 !pc_load_out)
		else $error("accumulator branch target wrong");
	a_dir_b_load: assert property (
		take && req_in.op == bit_branch_xor_pkg::direction_load_op && req_in.file_addr == bit_branch_xor_pkg::DIR_SEL_B |=>
		port_b_direction_out == $past(acc_out) && $stable(port_a_direction_out) && $stable(port_c_direction_out))
		else $error("direction load wrong");
	a_lit_xor_acc: assert property (
		take && req_in.op == bit_branch_xor_pkg::literal_xor_op |=>
		acc_out == ($past(acc_out) ^ $past(req_in.literal[7:0])) && zero_update_out && !file_wr_out.we)
		else $error("literal xor wrong");
	a_reg_xor_file: assert property (
		take && req_in.op == bit_branch_xor_pkg::register_xor_op && req_in.dest_file |=>
		file_wr_out.we && file_wr_out.data == ($past(acc_out) ^ $past(file_rd_data_in)) && $stable(acc_out))
		else $error("register xor to file wrong");
	a_xor_zero_flag: assert property (
		zero_update_out |-> zero_flag_out ==
		((file_wr_out.we ? file_wr_out.data : acc_out) == bit_branch_xor_pkg::ALL_ZERO))
		else $error("zero flag wrong");

	c_skip_taken: cover property (flush_out && !pc_load_out);
	c_branch_back: cover property (pc_load_out && pc_target_out < $past(pc_in, 1));
	c_xor_zero: cover property (zero_update_out && zero_flag_out);
	c_req_while_busy: cover property (busy_out && req_in.valid);
endmodule : bit_branch_xor_execute

// ---- testbench.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

// ****************************************
// Self-checking bench for the execute stage
// ****************************************
module testbench;
	localparam int PC_W = 15;
	logic clk_in;
	logic rst_n_in;
	bit_branch_xor_pkg::exec_req_t req_in;
	logic [PC_W-1:0] pc_in;
	logic [7:0] file_rd_data_in;
	bit_branch_xor_pkg::file_wr_t file_wr_out;
	logic [7:0] acc_out;
	logic zero_flag_out;
	logic zero_update_out;
	logic pc_load_out;
	logic [PC_W-1:0] pc_target_out;
	logic flush_out;
	logic busy_out;
	logic [7:0] port_a_direction_out;
	logic [7:0] port_b_direction_out;
	logic [7:0] port_c_direction_out;
	int n_fail;
	int n_checks;
	logic [15:0] seed;
	logic [7:0] acc_m;
	logic zero_m;
	logic [7:0] dir_m [3];
	logic [15:0] r;
	logic [15:0] ra;
	logic [15:0] rb;
	logic [15:0] rp;

	bit_branch_xor_execute #(.PC_W(PC_W)) dut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.req_in(req_in),
		.pc_in(pc_in),
		.file_rd_data_in(file_rd_data_in),
		.file_wr_out(file_wr_out),
		.acc_out(acc_out),
		.zero_flag_out(zero_flag_out),
		.zero_update_out(zero_update_out),
		.pc_load_out(pc_load_out),
		.pc_target_out(pc_target_out),
		.flush_out(flush_out),
		.busy_out(busy_out),
		.port_a_direction_out(port_a_direction_out),
		.port_b_direction_out(port_b_direction_out),
		.port_c_direction_out(port_c_direction_out)
	);

	// Clock at 100 MHz
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Prints the counts and the verdict, then ends the run
	task report_and_stop;
		$display("Checks %0d, errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// Next value of the stimulus shift register
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : rnd

	// Expected result byte of the bit and xor operations
	function automatic logic [7:0] expect_result(input bit_branch_xor_pkg::exec_op_t o, input logic [7:0] acc,
			input logic [7:0] f, input logic [2:0] bsel, input logic [7:0] lit);
		logic [7:0] m;
		m = 8'h01 << bsel;
		if (o == bit_branch_xor_pkg::bit_clear_op) begin
			return f & ~m;
		end
		if (o == bit_branch_xor_pkg::bit_set_op) begin
			return f | m;
		end
		if (o == bit_branch_xor_pkg::literal_xor_op) begin
			return acc ^ lit;
		end
		return acc ^ f;
	endfunction : expect_result

	// Drives one instruction at the falling edge and checks the answer one cycle later
	task automatic run_op(input logic [3:0] op, input logic [6:0] addr, input logic [2:0] bsel, input logic dest,
			input logic [8:0] lit, input logic [7:0] f, input logic [PC_W-1:0] pc);
		bit_branch_xor_pkg::exec_op_t o;
		logic [7:0] res;
		logic we_e;
		logic fl_e;
		logic br_e;
		o = bit_branch_xor_pkg::exec_op_t'(op);
		req_in <= '{1'b1, o, addr, bsel, dest, lit};
		pc_in <= pc;
		file_rd_data_in <= f;
		@(negedge clk_in);
		br_e = (o == bit_branch_xor_pkg::relative_branch_op) || (o == bit_branch_xor_pkg::branch_by_accumulator_op);
		fl_e = br_e || (o == bit_branch_xor_pkg::skip_if_bit_clear_op && !f[bsel])
			|| (o == bit_branch_xor_pkg::skip_if_bit_set_op && f[bsel]);
		we_e = (o == bit_branch_xor_pkg::bit_clear_op) || (o == bit_branch_xor_pkg::bit_set_op)
			|| (o == bit_branch_xor_pkg::register_xor_op && dest);
		res = expect_result(o, acc_m, f, bsel, lit[7:0]);
		`CHK(file_wr_out.we, we_e)
		if (we_e) begin
			`CHK({file_wr_out.addr, file_wr_out.data}, {addr, res})
		end
		`CHK({flush_out, busy_out}, {fl_e, fl_e})
		`CHK(pc_load_out, br_e)
		if (o == bit_branch_xor_pkg::relative_branch_op) begin
			`CHK(pc_target_out, PC_W'(pc + 1 + {{(PC_W-9){lit[8]}}, lit}))
		end
		if (o == bit_branch_xor_pkg::branch_by_accumulator_op) begin
			`CHK(pc_target_out, PC_W'(pc + 1 + acc_m))
		end
		if (o == bit_branch_xor_pkg::direction_load_op && addr >= 7'h05 && addr <= 7'h07) begin
			dir_m[addr - 7'h05] = acc_m;
		end
		if (o == bit_branch_xor_pkg::literal_xor_op || o == bit_branch_xor_pkg::register_xor_op) begin
			zero_m = (res == 8'h00);
			if (o == bit_branch_xor_pkg::literal_xor_op || !dest) begin
				acc_m = res;
			end
		end
		`CHK(zero_update_out, (o == bit_branch_xor_pkg::literal_xor_op || o == bit_branch_xor_pkg::register_xor_op))
		`CHK({acc_out, zero_flag_out}, {acc_m, zero_m})
		`CHK({port_a_direction_out, port_b_direction_out, port_c_direction_out}, {dir_m[0], dir_m[1], dir_m[2]})
		if (fl_e) begin
			// A request during the second cycle must leave no trace
			req_in <= '{1'b1, bit_branch_xor_pkg::literal_xor_op, addr, bsel, 1'b1, 9'h0ff};
			@(negedge clk_in);
			`CHK({file_wr_out.we, pc_load_out, busy_out, zero_update_out}, 4'h0)
			`CHK(acc_out, acc_m)
		end
	endtask : run_op

	// Watchdog against a hang
	initial begin
		#200000;
		n_fail++;
		report_and_stop;
	end

	// Reset, corner cases, then random instructions
	initial begin
		seed = 16'h002f;
		n_fail = 0;
		n_checks = 0;
		rst_n_in = 1'b0;
		req_in = '0;
		pc_in = '0;
		file_rd_data_in = 8'h00;
		acc_m = 8'h00;
		zero_m = 1'b0;
		dir_m = '{8'hff, 8'hff, 8'hff};
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		`CHK({acc_out, zero_flag_out, file_wr_out.we, pc_load_out}, {8'h00, 3'h0})
		`CHK({port_a_direction_out, port_c_direction_out}, 16'hffff)
		run_op(4'h1, 7'h7f, 3'h7, 1'b0, 9'h000, 8'hff, 15'h0000);
		run_op(4'h2, 7'h00, 3'h0, 1'b0, 9'h000, 8'h00, 15'h0000);
		run_op(4'h8, 7'h00, 3'h0, 1'b0, 9'h05a, 8'h00, 15'h0000);
		for (int i = 4; i < 8; i++) begin
			run_op(4'h7, 7'(i), 3'h0, 1'b0, 9'h000, 8'h00, 15'h0000);
		end
		run_op(4'h6, 7'h00, 3'h0, 1'b0, 9'h000, 8'h00, 15'h7fff);
		run_op(4'h5, 7'h00, 3'h0, 1'b0, 9'h100, 8'h00, 15'h0000);
		run_op(4'h5, 7'h00, 3'h0, 1'b0, 9'h0ff, 8'h00, 15'h0100);
		run_op(4'h9, 7'h10, 3'h0, 1'b1, 9'h000, 8'h00, 15'h0000);
		run_op(4'h9, 7'h10, 3'h0, 1'b0, 9'h000, 8'h5a, 15'h0000);
		run_op(4'h3, 7'h20, 3'h3, 1'b0, 9'h000, 8'hf7, 15'h0000);
		run_op(4'h3, 7'h20, 3'h3, 1'b0, 9'h000, 8'h08, 15'h0000);
		run_op(4'h4, 7'h20, 3'h6, 1'b0, 9'h000, 8'h40, 15'h0000);
		run_op(4'h4, 7'h20, 3'h6, 1'b0, 9'h000, 8'hbf, 15'h0000);
		for (int i = 0; i < 400; i++) begin
			r = rnd();
			ra = rnd();
			rb = rnd();
			rp = rnd();
			run_op(4'(r % 10), (r[6:4] == 3'h0) ? 7'h05 + 7'(r[8:7]) : ra[6:0], ra[9:7], r[9],
				(r[3:0] == 4'h0) ? {1'b0, acc_m} : rb[8:0], (r[3:0] == 4'h1) ? acc_m : rb[15:8],
				PC_W'(rp));
		end
		req_in <= '0;
		@(negedge clk_in);
		report_and_stop;
	end
endmodule : testbench
